// File: common/dru_params.svh
// Constants of the firmware-upgrade request and descriptor responder
`ifndef DRU_PARAMS_SVH
`define DRU_PARAMS_SVH
// ==================================================
// Request types and codes
`define DRU_RT_OUT 8'h21
`define DRU_RT_IN 8'ha1
`define DRU_RT_STD_IN 8'h80
`define DRU_REQ_DETACH 8'h00
`define DRU_REQ_DNLOAD 8'h01
`define DRU_REQ_UPLOAD 8'h02
`define DRU_REQ_GETSTATUS 8'h03
`define DRU_REQ_CLRSTATUS 8'h04
`define DRU_REQ_GETSTATE 8'h05
`define DRU_REQ_ABORT 8'h06
`define DRU_GET_DESC 8'h06
`define DRU_IF_INDEX 16'h0000
`define DRU_ZERO16 16'h0000
`define DRU_STATUS_LEN 16'h0006
`define DRU_STATE_LEN 16'h0001
// ==================================================
// Device descriptor fields
`define DRU_DEV_LEN 8'h12
`define DRU_DEV_TYPE 8'h01
`define DRU_BCD_USB 16'h0100
`define DRU_CLASS 8'hfe
`define DRU_SUBCLASS 8'h01
`define DRU_PROTO 8'h00
`define DRU_MPS0 8'h20
`define DRU_STR_NONE 8'h00
`define DRU_NUM_CFG 8'h01
// ==================================================
// Configuration, interface and functional descriptor fields
`define DRU_CFG_LEN 8'h09
`define DRU_CFG_TYPE 8'h02
`define DRU_CFG_TOTAL 16'h0019
`define DRU_NUM_IF 8'h01
`define DRU_CFG_VAL 8'h01
`define DRU_CFG_ATTR 8'h80
`define DRU_CFG_POWER 8'h32
`define DRU_IF_LEN 8'h09
`define DRU_IF_TYPE 8'h04
`define DRU_IF_NUM 8'h00
`define DRU_ALT 8'h00
`define DRU_NUM_EP 8'h00
`define DRU_FN_LEN 8'h07
`define DRU_FN_TYPE 8'h21
`define DRU_FN_ATTR 8'h03
`define DRU_FN_DETACH_MS 16'h00ff
`define DRU_FN_XFER 16'h0020
`define DRU_DEV_BYTES 16'h0012
`define DRU_CFG_BYTES 16'h0019
`define DRU_CFG_NIF_POS 8'h04
// ==================================================
// Packets and timing
`define DRU_PKT_LAST 5'h1f
`define DRU_PKT_FIRST 5'h00
`define DRU_MS_NS 1000000
`define DRU_CLK_NS 4
`endif

// File: common/dru_pkg.sv
// Types of the firmware-upgrade request and descriptor responder
package dru_pkg;
   // ==================================================
   // Decoded request kinds
   typedef enum logic [3:0]
   {
      DRU_K_DETACH = 4'h0,
      DRU_K_DNLOAD = 4'h1,
      DRU_K_UPLOAD = 4'h2,
      DRU_K_GETSTATUS = 4'h3,
      DRU_K_CLRSTATUS = 4'h4,
      DRU_K_GETSTATE = 4'h5,
      DRU_K_ABORT = 4'h6,
      DRU_K_DESC_DEV = 4'h7,
      DRU_K_DESC_CFG = 4'h8,
      DRU_K_BAD = 4'h9,
      DRU_K_OTHER = 4'ha
   } dru_kind_t;
   typedef enum logic [0:0] {DRU_PH_IDLE = 1'b0, DRU_PH_SEND = 1'b1} dru_phase_t;
   typedef enum logic [1:0]
   {
      DRU_SRC_DEV = 2'b00,
      DRU_SRC_CFG = 2'b01,
      DRU_SRC_STAT = 2'b10,
      DRU_SRC_STATE = 2'b11
   } dru_src_t;
   // Setup packet as delivered by the USB controller
   typedef struct packed
   {
      logic [7:0] req_type;
      logic [7:0] request;
      logic [15:0] value;
      logic [15:0] index;
      logic [15:0] length;
   } dru_setup_t;
   // Status reply fields supplied by the upgrade engine
   typedef struct packed
   {
      logic [7:0] str_idx;
      logic [7:0] next_state;
      logic [23:0] poll_ms;
      logic [7:0] code;
   } dru_status_t;
   // Request handed to the upgrade engine
   typedef struct packed
   {
      dru_kind_t kind;
      logic [15:0] value;
      logic [15:0] length;
   } dru_req_t;
   // Whole state of the responder
   typedef struct packed
   {
      dru_phase_t phase;
      dru_src_t src;
      logic [7:0] idx;
      logic [15:0] left;
      logic [4:0] pkt;
      logic [47:0] snap;
      logic tx_valid;
      logic [7:0] tx_data;
      logic tx_last;
      logic tx_done;
      logic req_valid;
      dru_req_t req;
      logic stall;
      logic ack;
      logic det_on;
      logic [15:0] det_ms;
      logic [17:0] det_cyc;
      logic det_expired;
   } dru_state_t;
endpackage

// File: hdl/dru_responder.sv
// Firmware-upgrade class request decoder and descriptor responder on endpoint 0
//
// How it works
// R1: Decode seven class requests, codes zero to six
// R2: Detach: out type, timeout value, no data
// R3: Download: out type, block, host data follows
// R4: Upload: in type, block, device returns bytes
// R5: Get status returns exactly six bytes
// R6: Clear status: out type, no data stage
// R7: Get state returns one state byte
// R8: Abort: out type, no data stage
// R9: Expose one device, config, interface, functional set
// R10: Device descriptor only in upgrade mode
// R11: Device descriptor length, type, USB release
// R12: Device class FEh, subclass 01h, protocol 00h
// R13: Endpoint zero packet size thirty-two
// R14: Identifiers at 8/10/12, string indices zero
// R15: One configuration at offset seventeen
// R16: Configuration reports one interface
// R17: Interface number always zero
// R18: Interface length, type, alternate, no endpoints
// R19: Interface class, subclass, protocol, string zero
// R20: Alternate settings may name segments, optional
// R21: Status bytes: code, poll wait, state, string
// R22: Endpoint zero only, 32-byte packets
// R23: Detach timeout without bus reset ends reconfiguration
// R24: Stall mismatching class requests
`timescale 1ns/1ps
`include "dru_params.svh"

module dru_responder
#(
   parameter int MS_CYCLES = `DRU_MS_NS / `DRU_CLK_NS,
   parameter logic [15:0] VENDOR_ID = 16'h1234, // Arbitrary value
   parameter logic [15:0] PRODUCT_ID = 16'h5678, // Arbitrary value
   parameter logic [15:0] RELEASE_ID = 16'h0001 // Arbitrary value
)
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic usb_bus_reset,
   input wire logic dfu_mode,
   input wire logic setup_valid,
   input wire dru_pkg::dru_setup_t setup,
   input wire dru_pkg::dru_status_t status_in,
   input wire logic [7:0] dev_state,
   input wire logic tx_ready,
   output logic tx_valid,
   output logic [7:0] tx_data,
   output logic tx_last,
   output logic tx_done,
   output logic req_valid,
   output dru_pkg::dru_req_t req,
   output logic stall,
   output logic ack,
   output logic detach_expired
);
   import dru_pkg::*;

   // ==================================================
   // Descriptor images, byte 0 in the low bits
   // Device descriptor, only served in upgrade mode
   localparam logic [143:0] DEV_IMG =
   {
      `DRU_NUM_CFG, // [R15]
      `DRU_STR_NONE, `DRU_STR_NONE, `DRU_STR_NONE, // [R14]
      RELEASE_ID, PRODUCT_ID, VENDOR_ID, // [R14]
      `DRU_MPS0, // [R13] [R22]
      `DRU_PROTO, `DRU_SUBCLASS, `DRU_CLASS, // [R12] [R10]
      `DRU_BCD_USB, `DRU_DEV_TYPE, `DRU_DEV_LEN // [R11]
   };
   // Configuration, then interface, then functional descriptor
   // Only alternate setting zero exists, so no segment strings are needed
   localparam logic [199:0] CFG_IMG =
   {
      `DRU_FN_XFER, `DRU_FN_DETACH_MS, `DRU_FN_ATTR,
      `DRU_FN_TYPE, `DRU_FN_LEN, // [R9]
      `DRU_STR_NONE, `DRU_PROTO, `DRU_SUBCLASS, `DRU_CLASS, // [R19]
      `DRU_NUM_EP, `DRU_ALT, // [R18] [R20]
      `DRU_IF_NUM, // [R17]
      `DRU_IF_TYPE, `DRU_IF_LEN, // [R18]
      `DRU_CFG_POWER, `DRU_CFG_ATTR, `DRU_STR_NONE, `DRU_CFG_VAL,
      `DRU_NUM_IF, // [R16]
      `DRU_CFG_TOTAL, `DRU_CFG_TYPE, `DRU_CFG_LEN // [R9]
   };
   // Last cycle of one millisecond
   localparam logic [17:0] MS_LAST = 18'(MS_CYCLES - 1);

   // ==================================================
   // Functions
   // Classify a setup packet; shared by the logic and its checks
   function automatic dru_kind_t dru_decode(input dru_setup_t s, input logic mode);
      dru_kind_t k;
      logic out_t;
      logic in_t;
      logic v0;
      k = DRU_K_OTHER;
      out_t = (s.req_type == `DRU_RT_OUT);
      in_t = (s.req_type == `DRU_RT_IN);
      v0 = (s.value == `DRU_ZERO16);
      if (s.req_type == `DRU_RT_STD_IN && s.request == `DRU_GET_DESC)
      begin
         // Descriptors exist only in upgrade mode
         k = DRU_K_BAD; // [R10]
         if (mode && s.value[15:8] == `DRU_DEV_TYPE)
         begin
            k = DRU_K_DESC_DEV; // [R10]
         end
         else if (mode && s.value[15:8] == `DRU_CFG_TYPE)
         begin
            k = DRU_K_DESC_CFG; // [R9]
         end
      end
      else if (out_t || in_t)
      begin
         // Anything not matching below stalls
         k = DRU_K_BAD; // [R24]
         if (s.index == `DRU_IF_INDEX) // [R1]
         begin
            case (s.request)
               `DRU_REQ_DETACH:
                  if (out_t && s.length == `DRU_ZERO16) k = DRU_K_DETACH; // [R2]
               `DRU_REQ_DNLOAD:
                  if (out_t) k = DRU_K_DNLOAD; // [R3]
               `DRU_REQ_UPLOAD:
                  if (in_t) k = DRU_K_UPLOAD; // [R4]
               `DRU_REQ_GETSTATUS:
                  if (in_t && v0 && s.length == `DRU_STATUS_LEN) k = DRU_K_GETSTATUS; // [R5]
               `DRU_REQ_CLRSTATUS:
                  if (out_t && v0 && s.length == `DRU_ZERO16) k = DRU_K_CLRSTATUS; // [R6]
               `DRU_REQ_GETSTATE:
                  if (in_t && v0 && s.length == `DRU_STATE_LEN) k = DRU_K_GETSTATE; // [R7]
               `DRU_REQ_ABORT:
                  if (out_t && v0 && s.length == `DRU_ZERO16) k = DRU_K_ABORT; // [R8]
               default:
                  k = DRU_K_BAD; // [R24]
            endcase
         end
      end
      return k;
   endfunction

   // Byte of the selected source at a given position
   function automatic logic [7:0] dru_pick(input dru_src_t src, input logic [7:0] i,
                                            input logic [47:0] snap);
      logic [7:0] b;
      b = snap[7:0];
      unique case (src)
         DRU_SRC_DEV: b = DEV_IMG[int'(i) * 8 +: 8];
         DRU_SRC_CFG: b = CFG_IMG[int'(i) * 8 +: 8];
         DRU_SRC_STAT: b = snap[int'(i) * 8 +: 8];
         DRU_SRC_STATE: b = snap[7:0];
      endcase
      return b;
   endfunction

   // ==================================================
   // State
   dru_state_t st_reg; // All registers of the block except the check counters
   dru_state_t st_next; // Their next values
   dru_kind_t kind; // Decode of the current setup
   logic [15:0] src_len; // Size of the chosen source
   logic [15:0] send_len; // Bytes to send, clipped by the host length

   // Decode of the incoming setup packet
   always_comb
   begin
      kind = dru_decode(setup, dfu_mode);
      src_len = `DRU_DEV_BYTES;
      if (kind == DRU_K_DESC_CFG)
      begin
         src_len = `DRU_CFG_BYTES;
      end
      // Host may ask for less than the whole descriptor
      send_len = (setup.length < src_len) ? setup.length : src_len;
   end

   // ==================================================
   // Next-state logic
   always_comb
   begin
      st_next = st_reg;
      // Pulses last one cycle
      st_next.req_valid = 1'b0;
      st_next.stall = 1'b0;
      st_next.ack = 1'b0;
      st_next.tx_done = 1'b0;
      st_next.det_expired = 1'b0;

      // Detach timeout in whole milliseconds
      if (st_reg.det_on)
      begin
         if (st_reg.det_cyc == MS_LAST)
         begin
            st_next.det_cyc = 18'h00000;
            if (st_reg.det_ms <= 16'h0001)
            begin
               // No bus reset came in time: back to normal operation
               st_next.det_on = 1'b0;
               st_next.det_expired = 1'b1; // [R23]
            end
            else
            begin
               st_next.det_ms = st_reg.det_ms - 16'h0001;
            end
         end
         else
         begin
            st_next.det_cyc = st_reg.det_cyc + 18'h00001;
         end
      end

      // Byte handshake on the endpoint 0 IN stream
      if (st_reg.phase == DRU_PH_SEND && st_reg.tx_valid && tx_ready)
      begin
         if (st_reg.left == 16'h0001)
         begin
            st_next.phase = DRU_PH_IDLE;
            st_next.tx_valid = 1'b0;
            st_next.tx_last = 1'b0;
            st_next.tx_done = 1'b1;
         end
         else
         begin
            st_next.idx = st_reg.idx + 8'h01;
            st_next.left = st_reg.left - 16'h0001;
            // Packet position wraps after 32 bytes
            st_next.pkt = (st_reg.pkt == `DRU_PKT_LAST) ? `DRU_PKT_FIRST
                          : st_reg.pkt + 5'h01; // [R22]
            st_next.tx_data = dru_pick(st_reg.src, st_next.idx, st_reg.snap);
            st_next.tx_last = (st_next.left == 16'h0001) ||
                              (st_next.pkt == `DRU_PKT_LAST); // [R22]
         end
      end

      // A new setup cancels any transfer in flight, as USB demands
      if (setup_valid)
      begin
         st_next.phase = DRU_PH_IDLE;
         st_next.tx_valid = 1'b0;
         st_next.tx_last = 1'b0;
         st_next.idx = 8'h00;
         st_next.pkt = `DRU_PKT_FIRST;
         st_next.req.kind = kind;
         st_next.req.value = setup.value;
         st_next.req.length = setup.length;
         unique case (kind)
            DRU_K_DETACH:
            begin
               // Timer restarts with the host's timeout
               st_next.req_valid = 1'b1;
               st_next.ack = 1'b1; // [R2]
               st_next.det_on = 1'b1; // [R23]
               st_next.det_ms = setup.value;
               st_next.det_cyc = 18'h00000;
            end
            DRU_K_CLRSTATUS, DRU_K_ABORT:
            begin
               st_next.req_valid = 1'b1;
               st_next.ack = 1'b1; // [R6] [R8]
            end
            DRU_K_DNLOAD, DRU_K_UPLOAD:
            begin
               // Data stage is moved by the upgrade engine
               st_next.req_valid = 1'b1; // [R3] [R4]
            end
            DRU_K_GETSTATUS:
            begin
               // Snapshot so the reply is consistent across bytes
               st_next.req_valid = 1'b1;
               st_next.snap = status_in; // [R21]
               st_next.src = DRU_SRC_STAT;
               st_next.left = `DRU_STATUS_LEN; // [R5]
               st_next.phase = DRU_PH_SEND;
               st_next.tx_valid = 1'b1;
               st_next.tx_data = status_in.code; // [R21]
               st_next.tx_last = 1'b0;
            end
            DRU_K_GETSTATE:
            begin
               st_next.req_valid = 1'b1;
               st_next.snap = {40'h0000000000, dev_state};
               st_next.src = DRU_SRC_STATE;
               st_next.left = `DRU_STATE_LEN; // [R7]
               st_next.phase = DRU_PH_SEND;
               st_next.tx_valid = 1'b1;
               st_next.tx_data = dev_state; // [R7]
               st_next.tx_last = 1'b1;
            end
            DRU_K_DESC_DEV, DRU_K_DESC_CFG:
            begin
               st_next.src = (kind == DRU_K_DESC_DEV) ? DRU_SRC_DEV : DRU_SRC_CFG;
               if (send_len == `DRU_ZERO16)
               begin
                  // Zero-length read: nothing to send
                  st_next.ack = 1'b1;
               end
               else
               begin
                  st_next.left = send_len;
                  st_next.phase = DRU_PH_SEND;
                  st_next.tx_valid = 1'b1;
                  st_next.tx_data = dru_pick(st_next.src, 8'h00, st_reg.snap); // [R11]
                  st_next.tx_last = (send_len == 16'h0001);
               end
            end
            DRU_K_BAD:
            begin
               st_next.stall = 1'b1; // [R24]
            end
            DRU_K_OTHER:
            begin
               // Other standard requests belong to the controller
               st_next.stall = 1'b0;
            end
         endcase
      end

      // Bus reset clears the transfer and cancels the detach timer
      if (usb_bus_reset)
      begin
         st_next.phase = DRU_PH_IDLE;
         st_next.tx_valid = 1'b0;
         st_next.tx_last = 1'b0;
         st_next.det_on = 1'b0; // [R23]
         st_next.det_expired = 1'b0;
         st_next.req_valid = 1'b0;
         st_next.ack = 1'b0;
         st_next.stall = 1'b0;
      end
   end

   // ==================================================
   // Registers
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // Outputs come straight from the state flops
   assign tx_valid = st_reg.tx_valid;
   assign tx_data = st_reg.tx_data;
   assign tx_last = st_reg.tx_last;
   assign tx_done = st_reg.tx_done;
   assign req_valid = st_reg.req_valid;
   assign req = st_reg.req;
   assign stall = st_reg.stall;
   assign ack = st_reg.ack;
   assign detach_expired = st_reg.det_expired;

   // ==================================================
   // Checks
   logic [5:0] run_cnt; // Bytes since the last packet end, only for checks
   logic [15:0] xfer_cnt; // Bytes since the last setup, only for checks

   // Counts handshaked bytes inside one packet
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         run_cnt <= 6'h00;
      end
      else if (setup_valid || usb_bus_reset || (tx_valid && tx_ready && tx_last))
      begin
         run_cnt <= 6'h00;
      end
      else if (tx_valid && tx_ready)
      begin
         run_cnt <= run_cnt + 6'h01;
      end
   end

   // Counts handshaked bytes of the whole reply, so its length can be checked
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         xfer_cnt <= 16'h0000;
      end
      else if (setup_valid || usb_bus_reset)
      begin
         xfer_cnt <= 16'h0000;
      end
      else if (tx_valid && tx_ready)
      begin
         xfer_cnt <= xfer_cnt + 16'h0001;
      end
   end

   stall_exclusive_a: assert property (@(posedge core_clk) disable iff (reset) // [R24]
      stall |-> !ack && !req_valid && !tx_valid)
      else $error("stall raised together with an accept");

   bad_index_a: assert property (@(posedge core_clk) disable iff (reset) // [R1]
      setup_valid && !usb_bus_reset && setup.req_type == `DRU_RT_OUT
      && setup.index != `DRU_IF_INDEX |=> stall)
      else $error("class request to wrong interface not stalled");

   detach_accept_a: assert property (@(posedge core_clk) disable iff (reset) // [R2]
      setup_valid && !usb_bus_reset && kind == DRU_K_DETACH
      |=> ack && req_valid && req.kind == DRU_K_DETACH ##1 (!ack || $past(setup_valid)))
      else $error("detach not acknowledged for exactly one cycle");

   status_six_a: assert property (@(posedge core_clk) disable iff (reset) // [R5]
      tx_done && st_reg.src == DRU_SRC_STAT && !$past(setup_valid)
      |-> xfer_cnt == `DRU_STATUS_LEN && !tx_valid)
      else $error("status reply is not six bytes");

   state_byte_a: assert property (@(posedge core_clk) disable iff (reset) // [R7]
      setup_valid && !usb_bus_reset && kind == DRU_K_GETSTATE
      |=> tx_valid && tx_last && tx_data == $past(dev_state))
      else $error("state reply byte wrong");

   desc_mode_a: assert property (@(posedge core_clk) disable iff (reset) // [R10]
      setup_valid && !usb_bus_reset && !dfu_mode
      && setup.req_type == `DRU_RT_STD_IN && setup.request == `DRU_GET_DESC |=> stall)
      else $error("descriptor served outside upgrade mode");

   dev_len_a: assert property (@(posedge core_clk) disable iff (reset) // [R11]
      setup_valid && !usb_bus_reset && kind == DRU_K_DESC_DEV
      && setup.length != `DRU_ZERO16 |=> tx_valid && tx_data == `DRU_DEV_LEN)
      else $error("device descriptor does not open with its length");

   cfg_nif_a: assert property (@(posedge core_clk) disable iff (reset) // [R16]
      st_reg.phase == DRU_PH_SEND && st_reg.src == DRU_SRC_CFG
      && st_reg.idx == `DRU_CFG_NIF_POS |-> tx_data == `DRU_NUM_IF)
      else $error("configuration interface count wrong");

   packet_size_a: assert property (@(posedge core_clk) disable iff (reset) // [R22]
      tx_valid |-> run_cnt < 6'h20)
      else $error("packet longer than 32 bytes");

   detach_end_a: assert property (@(posedge core_clk) disable iff (reset) // [R23]
      detach_expired |-> $past(st_reg.det_on) && !$past(usb_bus_reset))
      else $error("detach expiry without running timer");

endmodule

// File: tb/dru_host_model.sv
// Host model that takes IN bytes from endpoint zero at a random pace
`timescale 1ns/1ps

module dru_host_model
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic tx_valid,
   output logic tx_ready
);
   // Own seed, so the pacing does not disturb the bench's random stream
   logic [31:0] seed = 32'hdf33;
   initial tx_ready = 1'b0;
   // ==================================================
   // Pacing
   // A quarter of the cycles stall, so that held bytes are seen
   always @(posedge core_clk)
   begin
      tx_ready <= !reset && ($random(seed) % 4 != 0);
   end
endmodule

// File: tb/test_dru_responder.sv
// Self-checking bench of the upgrade request and descriptor responder
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_total++; \
   $display("MISMATCH t=%0t got %h exp %h", $time, (a), (b)); end end

module test_dru_responder;
   import dru_pkg::*;
   logic core_clk = 1'b0, reset = 1'b1, usb_bus_reset = 1'b0, dfu_mode = 1'b1;
   logic setup_valid = 1'b0, tx_ready;
   dru_setup_t setup = '0;
   dru_status_t status_in = '0;
   logic [7:0] dev_state = 8'h00;
   logic tx_valid, tx_last, tx_done, req_valid, stall, ack, detach_expired;
   logic [7:0] tx_data;
   dru_req_t req;
   int err_total = 0, samples_checked = 0, cycles = 0;
   logic [31:0] seed = 32'hdf33;
   // Expected events: tag in the upper byte, payload in the lower
   logic [15:0] exp_q[$];
   // Device descriptor, then config, interface and functional descriptors, first byte leftmost
   logic [343:0] dsc = {144'h120100_01fe0100_20341278_56010000_000001,
      200'h0902_19000101_00803209_0400_0000fe01_0000_072103ff_002000};
   logic [343:0] rdsc;
   logic [47:0] st;
   logic [7:0] sv;
   logic [31:0] pset = '0; // Value and length of the last setup taken

   always #2 core_clk = ~core_clk;

   // Short millisecond so the detach timer runs out in 20 or 30 cycles
   dru_responder #(.MS_CYCLES(10)) uut (.core_clk, .reset, .usb_bus_reset, .dfu_mode,
      .setup_valid, .setup, .status_in, .dev_state, .tx_ready, .tx_valid, .tx_data,
      .tx_last, .tx_done, .req_valid, .req, .stall, .ack, .detach_expired);
   dru_host_model host (.core_clk, .reset, .tx_valid, .tx_ready);

   // ==================================================
   // Helpers
   task automatic conclude;
      $display("checked %0d, mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic ex(input logic [15:0] v);
      exp_q.push_back(v);
   endtask

   // Byte k of v goes out k-th; the final one closes the packet
   task automatic exs(input logic [343:0] v, input int n);
      for (int k = 0; k < n; k++)
         ex({(k == n - 1) ? 8'h07 : 8'h01, v[8*k+:8]});
      ex(16'h0600);
   endtask

   // With more set the strobe stays up for a back-to-back setup
   task automatic rq(input logic [7:0] t, r, input logic [15:0] v, i, l,
                     input bit more = 1'b0);
      setup_valid <= 1'b1;
      setup <= '{t, r, v, i, l};
      @(posedge core_clk);
      if (!more)
         setup_valid <= 1'b0;
   endtask

   // Bounded wait until every noted event has been seen
   task automatic drain;
      int n;
      for (n = 0; n < 300 && exp_q.size() != 0; n++)
         @(posedge core_clk);
      repeat (3) @(posedge core_clk);
   endtask

   task automatic see(input logic [15:0] v);
      logic [15:0] e;
      if (exp_q.size() == 0)
      begin
         err_total++;
         $display("MISMATCH t=%0t unexpected %h", $time, v);
      end
      else
      begin
         e = exp_q.pop_front();
         `CHK(v, e)
      end
   endtask

   // ==================================================
   // Output watcher, fixed order within one cycle
   always @(posedge core_clk)
   begin
      if (!reset)
      begin
         if (req_valid === 1'b1 && req.kind <= DRU_K_ABORT) see({12'h040, req.kind});
         if (req_valid === 1'b1)
            `CHK({req.value, req.length}, pset)
         if (ack === 1'b1) see(16'h0200);
         if (stall === 1'b1) see(16'h0300);
         if (tx_valid === 1'b1 && tx_ready === 1'b1) see({tx_last ? 8'h07 : 8'h01, tx_data});
         if (tx_done === 1'b1) see(16'h0600);
         if (detach_expired === 1'b1) see(16'h0500);
         if (setup_valid === 1'b1) pset <= {setup.value, setup.length};
      end
   end

   // Hang guard, well above the few hundred cycles of the run
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         err_total++;
         conclude();
      end
   end

   // ==================================================
   // Main sequence
   initial
   begin
      rdsc = {<<8{dsc}};
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      @(posedge core_clk);
      // Detach, 2 ms, runs out without a bus reset
      ex(16'h0400); ex(16'h0200); ex(16'h0500);
      rq(8'h21, 8'h00, 16'h0002, 16'h0000, 16'h0000);
      drain();
      // Detach cancelled by a bus reset: no expiry may follow
      ex(16'h0400); ex(16'h0200);
      rq(8'h21, 8'h00, 16'h0003, 16'h0000, 16'h0000);
      drain();
      usb_bus_reset <= 1'b1;
      @(posedge core_clk);
      usb_bus_reset <= 1'b0;
      repeat (60) @(posedge core_clk);
      // Clear status and abort, back to back
      ex(16'h0404); ex(16'h0200); ex(16'h0406); ex(16'h0200);
      rq(8'h21, 8'h04, 16'h0000, 16'h0000, 16'h0000, 1'b1);
      rq(8'h21, 8'h06, 16'h0000, 16'h0000, 16'h0000);
      drain();
      // Download and upload are only announced
      ex(16'h0401); ex(16'h0402);
      rq(8'h21, 8'h01, 16'h0007, 16'h0000, 16'h0040, 1'b1);
      rq(8'ha1, 8'h02, 16'h0008, 16'h0000, 16'h0010);
      drain();
      // Get status with random fields, six bytes, low byte first
      st = 48'({$random(seed), $random(seed)});
      status_in <= st;
      ex(16'h0403);
      exs(344'(st), 6);
      rq(8'ha1, 8'h03, 16'h0000, 16'h0000, 16'h0006);
      drain();
      // Get state returns one snapshot byte
      sv = 8'($random(seed));
      dev_state <= sv;
      ex(16'h0405);
      exs(344'(sv), 1);
      rq(8'ha1, 8'h05, 16'h0000, 16'h0000, 16'h0001);
      drain();
      // Device descriptor in full, then cut short by the host length
      exs(rdsc, 18);
      rq(8'h80, 8'h06, 16'h0100, 16'h0000, 16'h0012);
      drain();
      exs(rdsc, 8);
      rq(8'h80, 8'h06, 16'h0100, 16'h0000, 16'h0008);
      drain();
      // Zero-length descriptor read is only acknowledged
      ex(16'h0200);
      rq(8'h80, 8'h06, 16'h0100, 16'h0000, 16'h0000);
      drain();
      // Whole configuration set, clipped from a longer host length
      exs(rdsc >> 144, 25);
      rq(8'h80, 8'h06, 16'h0200, 16'h0000, 16'h0040);
      drain();
      // Refusals: bad code, index, length, value, descriptor type
      repeat (5) ex(16'h0300);
      rq(8'h21, 8'h07, 16'h0000, 16'h0000, 16'h0000, 1'b1);
      rq(8'h21, 8'h04, 16'h0000, 16'h0001, 16'h0000, 1'b1);
      rq(8'ha1, 8'h03, 16'h0000, 16'h0000, 16'h0005, 1'b1);
      rq(8'ha1, 8'h05, 16'h0001, 16'h0000, 16'h0001, 1'b1);
      rq(8'h80, 8'h06, 16'h0300, 16'h0000, 16'h0009);
      drain();
      // Descriptor outside upgrade mode is refused
      dfu_mode <= 1'b0;
      ex(16'h0300);
      rq(8'h80, 8'h06, 16'h0100, 16'h0000, 16'h0012);
      drain();
      // Another standard request gets no answer at all
      rq(8'h80, 8'h00, 16'h0000, 16'h0000, 16'h0002);
      repeat (20) @(posedge core_clk);
      `CHK(exp_q.size(), 0)
      conclude();
   end
endmodule
